//--- flash_cpu_reprogram_sequencer.sv
// Purpose : Command sequencer for CPU reprogramming of on-chip flash
// Assumes : Software polls ready before each command and stays off
//           the array while an automatic run is in progress
// Notes   : Page programming writes one 16-bit word per command
//
// Functional notes
// - Upper data byte ignored except the page programming data cycle.
// - Command byte 41 hex decodes as page programming.
// - Further page programs accepted in status-read mode if no error.
// - Program or block erase on a locked block sets both erase and program error.
// - Ready/busy flag follows the status ready bit exactly.
// - Commands only at even addresses; data word spans even and odd.
module flash_cpu_reprogram_sequencer #(
  parameter int PROG_TIME_NS  = 20000,
  parameter int ERASE_TIME_NS = 200000
) (
  // Clock and reset
  input  wire logic                                  clk_sys_in,
  input  wire logic                                  rst_n_in,
  // Mode control
  input  wire logic                                  reprog_sel_in,
  input  wire logic                                  lock_override_in,
  input  wire logic [flash_seq_pkg::NUM_BLOCKS-1:0]  lock_bits_in,
  // CPU command writes
  input  wire logic                                  cpu_wr_in,
  input  wire logic [flash_seq_pkg::ADDR_WIDTH-1:0]  cpu_addr_in,
  input  wire logic [15:0]                           cpu_data_in,
  // Status
  output logic [7:0]                                 status_out,
  output logic                                       ready_busy_flag_out,
  output logic                                       lock_status_out,
  output flash_seq_pkg::read_mode_type               read_mode_out,
  output logic                                       mode_active_out,
  // Flash array requests
  output flash_seq_pkg::flash_req_type               flash_req_out
);
  import flash_seq_pkg::*;

  // ****************************************************************
  // Derived timing
  // ****************************************************************
  localparam int PROG_CYCLES  = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [TIMER_WIDTH-1:0] PROG_LOAD =
    TIMER_WIDTH'(PROG_CYCLES - 1);
  localparam logic [TIMER_WIDTH-1:0] ERASE_LOAD =
    TIMER_WIDTH'(ERASE_CYCLES - 1);

  seq_state_type           cur;
  seq_state_type           next_cur;
  logic                    timer_start;
  logic [TIMER_WIDTH-1:0]  timer_load;
  logic                    timer_busy;
  logic                    timer_done;
  logic                    wr_even;
  logic [7:0]              cmd_byte;
  logic [BLOCK_WIDTH-1:0]  blk;
  logic                    blk_locked;

  // ****************************************************************
  // Command decode
  // ****************************************************************

  // Odd-address writes never reach the decoder
  assign wr_even    = cpu_wr_in && !cpu_addr_in[0] && cur.mode_on;
  assign cmd_byte   = cpu_data_in[7:0];
  assign blk        = cpu_addr_in[BLOCK_LSB +: BLOCK_WIDTH];
  assign blk_locked = lock_bits_in[blk] && !lock_override_in;

  // One combinational pass builds the next state
  always_comb begin
    next_cur               = cur;
    next_cur.req.prog      = 1'b0;
    next_cur.req.erase     = 1'b0;
    next_cur.req.erase_all = 1'b0;
    timer_start            = 1'b0;
    timer_load             = PROG_LOAD;
    // Mode entry needs a low select seen before the high one
    next_cur.sel_low_seen  = cur.sel_low_seen || !reprog_sel_in;
    next_cur.mode_on       = reprog_sel_in &&
                             (cur.mode_on || cur.sel_low_seen);
    case (cur.phase)
      PH_IDLE: begin
        if (wr_even) begin
          if (cmd_byte == CMD_PAGE_PROG) begin
            // Continuous programming only while no error stands
            if (!cur.program_error) begin
              next_cur.phase = PH_SECOND;
              next_cur.cmd   = cmd_byte;
            end
          end else if (cmd_byte == CMD_BLOCK_ERASE ||
                       cmd_byte == CMD_ERASE_ALL) begin
            next_cur.phase = PH_SECOND;
            next_cur.cmd   = cmd_byte;
          end else if (cmd_byte == CMD_READ_STATUS) begin
            next_cur.read_mode = READ_STATUS_MODE;
          end else if (cmd_byte == CMD_CLEAR_STATUS) begin
            next_cur.erase_error   = 1'b0;
            next_cur.program_error = 1'b0;
          end else if (cmd_byte == CMD_READ_ARRAY) begin
            next_cur.read_mode = READ_ARRAY_MODE;
          end else if (cmd_byte == CMD_READ_LOCK) begin
            next_cur.read_mode  = READ_LOCK_MODE;
            next_cur.lock_state = lock_bits_in[blk];
          end
        end
      end
      PH_SECOND: begin
        if (wr_even) begin
          next_cur.phase     = PH_IDLE;
          next_cur.read_mode = READ_STATUS_MODE;
          if (cur.cmd == CMD_PAGE_PROG) begin
            if (blk_locked) begin
              // Locked target fails both ways
              next_cur.erase_error   = 1'b1;
              next_cur.program_error = 1'b1;
            end else begin
              // Full 16-bit word kept for the data cycle
              next_cur.req.prog = 1'b1;
              next_cur.req.addr = cpu_addr_in;
              next_cur.req.data = cpu_data_in;
              next_cur.phase    = PH_BUSY;
              timer_start       = 1'b1;
            end
          end else if (cmd_byte != CMD_ERASE_CONF) begin
            // A broken erase sequence is reported as a full error
            next_cur.erase_error   = 1'b1;
            next_cur.program_error = 1'b1;
          end else if (cur.cmd == CMD_BLOCK_ERASE && blk_locked) begin
            next_cur.erase_error   = 1'b1;
            next_cur.program_error = 1'b1;
          end else begin
            next_cur.req.erase     = (cur.cmd == CMD_BLOCK_ERASE);
            next_cur.req.erase_all = (cur.cmd == CMD_ERASE_ALL);
            next_cur.req.addr      = cpu_addr_in;
            next_cur.req.data      = 16'h0000;
            next_cur.phase         = PH_BUSY;
            timer_start            = 1'b1;
            timer_load             = ERASE_LOAD;
          end
        end
      end
      PH_BUSY: begin
        // Writes are not decoded while the array is busy
        if (timer_done) begin
          next_cur.phase = PH_IDLE;
        end
      end
      default: begin
        next_cur.phase = PH_IDLE;
      end
    endcase
    // Leaving the mode drops any half-entered command
    if (!next_cur.mode_on && next_cur.phase == PH_SECOND) begin
      next_cur.phase = PH_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // Automatic operation timer
  // ****************************************************************
  op_timer i_op_timer (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .start_in   (timer_start),
    .load_in    (timer_load),
    .busy_out   (timer_busy),
    .done_out   (timer_done)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Both ready views come from the same phase flop
  always_comb begin
    status_out               = SR_ZERO;
    status_out[SR_READY_BIT] = (cur.phase != PH_BUSY);
    status_out[SR_ERASE_BIT] = cur.erase_error;
    status_out[SR_PROG_BIT]  = cur.program_error;
  end
  assign ready_busy_flag_out = status_out[SR_READY_BIT];
  assign lock_status_out     = cur.lock_state;
  assign read_mode_out       = cur.read_mode;
  assign mode_active_out     = cur.mode_on;
  assign flash_req_out       = cur.req;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Done pulse still counts as busy: phase leaves busy one edge later
  a_ready_mirror: assert property (
    ready_busy_flag_out == status_out[SR_READY_BIT] &&
    ready_busy_flag_out == !(timer_busy || timer_done))
    else $error("ready flag differs from status ready bit");

  a_page_decode: assert property (
    cur.phase == PH_IDLE && wr_even && cmd_byte == 8'h41 &&
    !cur.program_error && reprog_sel_in
    |=> cur.phase == PH_SECOND && cur.cmd == 8'h41)
    else $error("page programming command not decoded");

  a_upper_ignored: assert property (
    cur.phase == PH_IDLE && wr_even && cpu_data_in[7:0] == 8'h70
    |=> cur.read_mode == READ_STATUS_MODE && cur.phase == PH_IDLE)
    else $error("command decode depended on upper byte");

  a_prog_word: assert property (
    cur.phase == PH_SECOND && cur.cmd == CMD_PAGE_PROG && wr_even &&
    !blk_locked && reprog_sel_in
    |=> flash_req_out.prog && flash_req_out.data == $past(cpu_data_in)
        ##1 !flash_req_out.prog)
    else $error("programming word not passed as one pulse");

  a_odd_ignored: assert property (
    cpu_wr_in && cpu_addr_in[0] && cur.phase == PH_IDLE && cur.mode_on
    |=> $stable(cur.read_mode) && $stable(status_out) &&
        cur.phase == PH_IDLE)
    else $error("odd address write changed the sequencer");

  a_lock_error: assert property (
    cur.phase == PH_SECOND && wr_even && blk_locked &&
    (cur.cmd == CMD_PAGE_PROG ||
     (cur.cmd == CMD_BLOCK_ERASE && cmd_byte == CMD_ERASE_CONF))
    |=> status_out[SR_ERASE_BIT] && status_out[SR_PROG_BIT] &&
        status_out[SR_READY_BIT] &&
        !flash_req_out.prog && !flash_req_out.erase)
    else $error("locked block change did not set both errors");

  a_busy_start: assert property (
    $rose(flash_req_out.prog) || $rose(flash_req_out.erase)
    |-> !ready_busy_flag_out ##1 !ready_busy_flag_out)
    else $error("busy not shown after an automatic start");

  a_cont_prog: assert property (
    cur.phase == PH_BUSY && timer_done
    |=> cur.read_mode == READ_STATUS_MODE && ready_busy_flag_out)
    else $error("program end left status-read mode");

  a_mode_entry: assert property (
    !cur.mode_on && !cur.sel_low_seen |=> !cur.mode_on)
    else $error("mode entered without a low select first");

  c_page_prog: cover property (
    flash_req_out.prog ##1 !ready_busy_flag_out);
  c_block_erase: cover property (flash_req_out.erase);
  c_lock_fail: cover property ($rose(status_out[SR_ERASE_BIT]));
  c_erase_all: cover property (flash_req_out.erase_all);

endmodule : flash_cpu_reprogram_sequencer

//--- flash_seq_pkg.sv
// Purpose : Shared constants and types for the flash reprogram sequencer
// Assumes : 250 MHz system clock, byte addresses into a 128 KB array
// Notes   : Command codes other than page programming are plain defaults
package flash_seq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMER_WIDTH   = 24;

  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int ADDR_WIDTH  = 17;
  localparam int BLOCK_LSB   = 14;
  localparam int BLOCK_WIDTH = 3;
  localparam int NUM_BLOCKS  = 8;

  // ****************************************************************
  // Command bytes (low data byte of a command cycle)
  // ****************************************************************
  localparam logic [7:0] CMD_PAGE_PROG    = 8'h41;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_ERASE_ALL    = 8'hA7;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_LOCK    = 8'h71;

  // ****************************************************************
  // Status byte field positions and reset values
  // ****************************************************************
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_BIT = 5;
  localparam int SR_PROG_BIT  = 4;
  localparam logic [7:0] SR_ZERO = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    READ_ARRAY_MODE,
    READ_STATUS_MODE,
    READ_LOCK_MODE
  } read_mode_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SECOND,
    PH_BUSY
  } phase_type;

  // Request toward the flash array
  typedef struct packed {
    logic                   prog;
    logic                   erase;
    logic                   erase_all;
    logic [ADDR_WIDTH-1:0]  addr;
    logic [15:0]            data;
  } flash_req_type;

  typedef struct packed {
    phase_type              phase;
    logic [7:0]             cmd;
    read_mode_type          read_mode;
    logic                   erase_error;
    logic                   program_error;
    logic                   sel_low_seen;
    logic                   mode_on;
    logic                   lock_state;
    flash_req_type          req;
  } seq_state_type;

  typedef struct packed {
    logic                   busy;
    logic                   done;
    logic [TIMER_WIDTH-1:0] count;
  } timer_state_type;

endpackage : flash_seq_pkg

//--- op_timer.sv
// Purpose : Down-counter that times one automatic program or erase run
// Assumes : start_in is a one-cycle pulse, never given while busy
// Notes   : done_out pulses one cycle as busy_out falls
module op_timer (
  // Clock and reset
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 rst_n_in,
  // Control
  input  wire logic                                 start_in,
  input  wire logic [flash_seq_pkg::TIMER_WIDTH-1:0] load_in,
  // Status
  output logic                                      busy_out,
  output logic                                      done_out
);
  import flash_seq_pkg::*;

  timer_state_type cur;
  timer_state_type next_cur;

  // Load on start, count down, finish at zero
  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    if (start_in) begin
      next_cur.busy  = 1'b1;
      next_cur.count = load_in;
    end else if (cur.busy) begin
      if (cur.count == '0) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.count = cur.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy_out = cur.busy;
  assign done_out = cur.done;

endmodule : op_timer

//--- cpu_model.sv
// Purpose : CPU side model that issues reprogram command writes
// Assumes : Inputs of the sequencer change at the falling clock edge
// Notes   : Between writes the buses show the inverse of the last value
module cpu_model (
  // Clock and status
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 ready_busy_flag_in,
  // Command bus
  output logic                                      reprog_sel_out,
  output logic                                      cpu_wr_out,
  output logic [flash_seq_pkg::ADDR_WIDTH-1:0]      cpu_addr_out,
  output logic [15:0]                               cpu_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_seq_pkg::*;

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Idle bus at time zero
  initial begin
    reprog_sel_out = 1'b0;
    cpu_wr_out     = 1'b0;
    cpu_addr_out   = '0;
    cpu_data_out   = 16'h0000;
  end

  // Select low for two edges, then high; a lone high would not count
  task automatic enter_mode();
    reprog_sel_out = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    reprog_sel_out = 1'b1;
    repeat (2) @(negedge clk_sys_in);
  endtask : enter_mode

  // One strobe; a data word carries both bytes together
  task automatic write_word(input logic [ADDR_WIDTH-1:0] addr,
                            input logic [15:0]           data);
    @(negedge clk_sys_in);
    cpu_wr_out   = 1'b1;
    cpu_addr_out = addr;
    cpu_data_out = data;
    @(negedge clk_sys_in);
    cpu_wr_out   = 1'b0;
    cpu_addr_out = ~addr; // Stale values must not look valid
    cpu_data_out = ~data;
  endtask : write_word

  // No command or array access until ready reads 1
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge clk_sys_in);
      ok = (ready_busy_flag_in === 1'b1);
    end
  endtask : wait_ready
endmodule : cpu_model

//--- flash_cpu_reprogram_sequencer_tb.sv
// Purpose : Self-checking bench for the flash reprogram sequencer
// Assumes : Short program and erase times to keep the run brief
// Notes   : Strobes and busy cycles are counted at the falling edge
module flash_cpu_reprogram_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_seq_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int PROG_CYC  = 40 / CLK_PERIOD_NS + 1;
  localparam int ERASE_CYC = 80 / CLK_PERIOD_NS + 1;
  logic                  clk_sys_in;
  logic                  rst_n_in;
  logic                  reprog_sel;
  logic                  lock_override;
  logic [NUM_BLOCKS-1:0] lock_bits;
  logic                  cpu_wr;
  logic [ADDR_WIDTH-1:0] cpu_addr;
  logic [15:0]           cpu_data;
  logic [7:0]            status;
  logic                  ready_flag;
  logic                  lock_status;
  read_mode_type         read_mode;
  logic                  mode_active;
  flash_req_type         req;
  int                    num_errors;
  int                    cmp_count;
  int                    prog_cnt;
  int                    erase_cnt;
  int                    all_cnt;
  int                    low_cnt;
  bit                    ok;

  flash_cpu_reprogram_sequencer #(
    .PROG_TIME_NS (40),
    .ERASE_TIME_NS(80)
  ) i_flash_cpu_reprogram_sequencer (
    .clk_sys_in         (clk_sys_in),
    .rst_n_in           (rst_n_in),
    .reprog_sel_in      (reprog_sel),
    .lock_override_in   (lock_override),
    .lock_bits_in       (lock_bits),
    .cpu_wr_in          (cpu_wr),
    .cpu_addr_in        (cpu_addr),
    .cpu_data_in        (cpu_data),
    .status_out         (status),
    .ready_busy_flag_out(ready_flag),
    .lock_status_out    (lock_status),
    .read_mode_out      (read_mode),
    .mode_active_out    (mode_active),
    .flash_req_out      (req)
  );

  cpu_model i_cpu_model (
    .clk_sys_in        (clk_sys_in),
    .ready_busy_flag_in(ready_flag),
    .reprog_sel_out    (reprog_sel),
    .cpu_wr_out        (cpu_wr),
    .cpu_addr_out      (cpu_addr),
    .cpu_data_out      (cpu_data)
  );

  // ****************************************************************
  // Tasks and monitor
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // One or two writes (none second if a1 is 1FFFF) then a bounded wait; a hang ends the run
  task automatic run(input logic [16:0] a0, input logic [15:0] d0,
                     input logic [16:0] a1, input logic [15:0] d1);
    {prog_cnt, erase_cnt, all_cnt, low_cnt} = '0;
    i_cpu_model.write_word(a0, d0);
    if (a1 != 17'h1FFFF) i_cpu_model.write_word(a1, d1);
    i_cpu_model.wait_ready(ok);
    if (!ok) begin
      num_errors++;
      print_verdict();
    end
  endtask : run

  // Strobes are one-cycle pulses, so each is seen at one falling edge
  always @(negedge clk_sys_in) begin
    if (rst_n_in === 1'b1) begin
      prog_cnt  += int'(req.prog === 1'b1);
      erase_cnt += int'(req.erase === 1'b1);
      all_cnt   += int'(req.erase_all === 1'b1);
      low_cnt   += int'(ready_flag === 1'b0);
      check("ready_flag", ready_flag, status[SR_READY_BIT]);
    end
  end

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n_in      = 1'b0;
    lock_override = 1'b0;
    lock_bits     = 8'h02;
    repeat (10) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    @(negedge clk_sys_in);
    check("reset_status", status, 8'h80);
    check("reset_mode", mode_active, 1'b0);
    // Writes before mode entry are dropped
    run(17'h00000, 16'h0070, 17'h1FFFF, 16'h0000);
    check("pre_mode_read", read_mode, READ_ARRAY_MODE);
    i_cpu_model.enter_mode();
    check("mode_active", mode_active, 1'b1);
    // Junk upper byte on the command, full word on the data
    run(17'h00100, 16'hFF41, 17'h00100, 16'hA5C3);
    check("prog_count", prog_cnt, 1);
    check("prog_data", req.data, 16'hA5C3);
    check("prog_addr", req.addr, 17'h00100);
    check("prog_busy", low_cnt, PROG_CYC);
    check("prog_read", read_mode, READ_STATUS_MODE);
    // Second program straight from status-read mode
    run(17'h00102, 16'h0041, 17'h00102, 16'h1234);
    check("cont_count", prog_cnt, 1);
    check("cont_data", req.data, 16'h1234);
    // Odd address command is ignored
    run(17'h00000, 16'h00FF, 17'h00001, 16'h0070);
    check("odd_cmd", read_mode, READ_ARRAY_MODE);
    // Locked block: program and erase both end in error
    run(17'h04000, 16'h0041, 17'h04000, 16'h5A5A);
    check("lock_prog_sr", status, 8'hB0);
    check("lock_prog_cnt", prog_cnt, 0);
    // Page command refused while the program error stands
    run(17'h00000, 16'h0041, 17'h00000, 16'h5A00);
    check("err_refuse_cnt", prog_cnt, 0);
    check("err_refuse_sr", status, 8'hB0);
    run(17'h00000, 16'h0050, 17'h04000, 16'h0020);
    run(17'h04000, 16'h00D0, 17'h1FFFF, 16'h0000);
    check("lock_erase_sr", status, 8'hB0);
    check("lock_erase_cnt", erase_cnt, 0);
    run(17'h00000, 16'h0050, 17'h04000, 16'h0071);
    check("clear_sr", status, 8'h80);
    check("lock_read", lock_status, 1'b1);
    check("lock_mode", read_mode, READ_LOCK_MODE);
    run(17'h00000, 16'h0071, 17'h1FFFF, 16'h0000);
    check("unlock_read", lock_status, 1'b0);
    // Override lets the locked block be programmed
    lock_override = 1'b1;
    run(17'h04000, 16'h0041, 17'h04002, 16'h00C3);
    check("ovr_count", prog_cnt, 1);
    check("ovr_sr", status, 8'h80);
    lock_override = 1'b0;
    // Block erase and erase-all on unlocked blocks
    run(17'h08000, 16'h0020, 17'h08000, 16'h00D0);
    check("erase_count", erase_cnt, 1);
    check("erase_busy", low_cnt, ERASE_CYC);
    lock_bits = 8'h00;
    run(17'h00000, 16'h00A7, 17'h00000, 16'h00D0);
    check("all_count", all_cnt, 1);
    check("all_sr", status, 8'h80);
    print_verdict();
  end
endmodule : flash_cpu_reprogram_sequencer_tb
